// file: rtl/phy_status_pkg.sv
`default_nettype none
package phy_status_pkg;
    // Management register addresses and override enable bit
    localparam logic [4:0] STATUS_ADDR = 5'h01;
    localparam logic [4:0] EXT_CTRL_ADDR = 5'h10;
    localparam int OVR_EN_BIT = 15;
    // Status word field positions
    localparam int T4_BIT = 15;
    localparam int CAP_MSB = 14;
    localparam int CAP_LSB = 11;
    localparam int RSV_MSB = 10;
    localparam int RSV_LSB = 7;
    localparam int PRE_BIT = 6;
    localparam int AN_DONE_BIT = 5;
    localparam int RFAULT_BIT = 4;
    localparam int AN_ABLE_BIT = 3;
    localparam int LINK_BIT = 2;
    localparam int JAB_BIT = 1;
    localparam int EXT_BIT = 0;
    // Reset values
    localparam logic [3:0] CAP_RST = 4'hF;
    localparam logic [3:0] RSV_RST = 4'h0;
    localparam logic PRE_RST = 1'b0;
    localparam logic LATCH_RST = 1'b0;
    localparam logic OVR_RST = 1'b0;
    // Frame layout counts and opcodes
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0B;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_HDR = 3'b010,
        S_TA = 3'b011,
        S_DATA = 3'b100
    } frame_state_t;

    typedef struct packed {
        logic an_complete;
        logic remote_fault;
        logic link_up;
        logic jabber;
    } phy_events_t;

    typedef struct packed {
        frame_state_t fsm;
        logic mdc_prev;
        logic [5:0] ones;
        logic [4:0] cnt;
        logic [11:0] hdr;
        logic [15:0] shift;
        logic is_read;
        logic hit;
        logic mdio_out;
        logic mdio_oe;
        logic [3:0] caps;
        logic [3:0] rsvd;
        logic pre_supp;
        logic an_done;
        logic rfault;
        logic link;
        logic jab;
        logic ovr_en;
    } status_state_t;
endpackage : phy_status_pkg
`default_nettype wire

// file: rtl/phy_status_reg.sv
`default_nettype none
module phy_status_reg #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire phy_status_pkg::phy_events_t events_i,
    output logic [3:0] caps_o,
    output logic preamble_supp_o
);
    phy_status_pkg::status_state_t st_reg;
    phy_status_pkg::status_state_t st_next;
    logic [1:0] pins_s;
    logic mdc_s;
    logic mdio_s;
    logic rd_pulse;
    logic wr_commit;
    logic [15:0] wdata;
    logic [15:0] stat_word;

    // Never fires: PHY_ADDR is 5 bits wide, so it cannot exceed 5'h1F
    if (PHY_ADDR > 5'h1F) begin : g_bad_addr
        $error("PHY_ADDR out of range");
    end

    function automatic logic [15:0] status_word(input phy_status_pkg::status_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[phy_status_pkg::T4_BIT] = 1'b0;
        w[phy_status_pkg::CAP_MSB:phy_status_pkg::CAP_LSB] = s.caps;
        w[phy_status_pkg::RSV_MSB:phy_status_pkg::RSV_LSB] = 4'h0;
        w[phy_status_pkg::PRE_BIT] = s.pre_supp;
        w[phy_status_pkg::AN_DONE_BIT] = s.an_done;
        w[phy_status_pkg::RFAULT_BIT] = s.rfault;
        w[phy_status_pkg::AN_ABLE_BIT] = 1'b1;
        w[phy_status_pkg::LINK_BIT] = s.link;
        w[phy_status_pkg::JAB_BIT] = s.jab;
        w[phy_status_pkg::EXT_BIT] = 1'b1;
        return w;
    endfunction : status_word

    // Pins come from the management clock domain
    sync_2ff #(.WIDTH(2)) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({mdc_i, mdio_i}),
        .q_o(pins_s)
    );
    assign mdc_s = pins_s[1];
    assign mdio_s = pins_s[0];

    always_comb begin
        st_next = st_reg;
        rd_pulse = 1'b0;
        wr_commit = 1'b0;
        wdata = {st_reg.shift[14:0], mdio_s};
        st_next.mdc_prev = mdc_s;
        if (mdc_s && !st_reg.mdc_prev) begin
            case (st_reg.fsm)
                phy_status_pkg::S_IDLE: begin
                    if (mdio_s) begin
                        if (st_reg.ones != phy_status_pkg::PREAMBLE_LEN) begin
                            st_next.ones = st_reg.ones + 6'h01;
                        end
                    end else begin
                        st_next.ones = 6'h00;
                        // Short preamble only accepted once suppression is granted
                        if (st_reg.ones == phy_status_pkg::PREAMBLE_LEN || st_reg.pre_supp) begin
                            st_next.fsm = phy_status_pkg::S_START;
                        end
                    end
                end
                phy_status_pkg::S_START: begin
                    st_next.cnt = 5'h00;
                    st_next.fsm = mdio_s ? phy_status_pkg::S_HDR : phy_status_pkg::S_IDLE;
                end
                phy_status_pkg::S_HDR: begin
                    st_next.hdr = {st_reg.hdr[10:0], mdio_s};
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == phy_status_pkg::HDR_LAST) begin
                        st_next.cnt = 5'h00;
                        st_next.fsm = phy_status_pkg::S_TA;
                    end
                end
                phy_status_pkg::S_TA: begin
                    if (st_reg.cnt == 5'h00) begin
                        st_next.cnt = 5'h01;
                        st_next.hit = (st_reg.hdr[9:5] == PHY_ADDR);
                        st_next.is_read = (st_reg.hdr[11:10] == phy_status_pkg::OP_READ);
                        if (st_reg.hdr[11:10] != phy_status_pkg::OP_READ &&
                                st_reg.hdr[11:10] != phy_status_pkg::OP_WRITE) begin
                            st_next.fsm = phy_status_pkg::S_IDLE;
                        end else if (st_reg.hdr[9:5] == PHY_ADDR &&
                                st_reg.hdr[11:10] == phy_status_pkg::OP_READ) begin
                            st_next.mdio_oe = 1'b1;
                            st_next.mdio_out = 1'b0;
                            if (st_reg.hdr[4:0] == phy_status_pkg::STATUS_ADDR) begin
                                st_next.shift = status_word(st_reg);
                                rd_pulse = 1'b1;
                            end else if (st_reg.hdr[4:0] == phy_status_pkg::EXT_CTRL_ADDR) begin
                                st_next.shift = {st_reg.ovr_en, 15'h0000};
                            end else begin
                                st_next.shift = 16'h0000;
                            end
                        end
                    end else begin
                        st_next.cnt = 5'h00;
                        st_next.fsm = phy_status_pkg::S_DATA;
                        if (st_reg.mdio_oe) begin
                            st_next.mdio_out = st_reg.shift[15];
                            st_next.shift = {st_reg.shift[14:0], 1'b0};
                        end
                    end
                end
                phy_status_pkg::S_DATA: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.is_read) begin
                        st_next.mdio_out = st_reg.shift[15];
                        st_next.shift = {st_reg.shift[14:0], 1'b0};
                    end else begin
                        st_next.shift = wdata;
                    end
                    if (st_reg.cnt == phy_status_pkg::DATA_LAST) begin
                        st_next.fsm = phy_status_pkg::S_IDLE;
                        st_next.ones = 6'h00;
                        st_next.mdio_oe = 1'b0;
                        st_next.mdio_out = 1'b0;
                        wr_commit = !st_reg.is_read && st_reg.hit;
                    end
                end
                default: begin
                    st_next.fsm = phy_status_pkg::S_IDLE;
                end
            endcase
        end
        if (wr_commit && st_reg.hdr[4:0] == phy_status_pkg::STATUS_ADDR &&
                st_reg.ovr_en) begin
            st_next.caps = wdata[phy_status_pkg::CAP_MSB:phy_status_pkg::CAP_LSB];
            st_next.rsvd = wdata[phy_status_pkg::RSV_MSB:phy_status_pkg::RSV_LSB];
            st_next.pre_supp = wdata[phy_status_pkg::PRE_BIT];
        end
        if (wr_commit && st_reg.hdr[4:0] == phy_status_pkg::EXT_CTRL_ADDR) begin
            st_next.ovr_en = wdata[phy_status_pkg::OVR_EN_BIT];
        end
        // Read clears latches, but a same-cycle event wins
        st_next.an_done = (st_reg.an_done && !rd_pulse) ||
            events_i.an_complete;
        st_next.rfault = (st_reg.rfault && !rd_pulse) || events_i.remote_fault;
        st_next.jab = (st_reg.jab && !rd_pulse) || events_i.jabber;
        st_next.link = rd_pulse ? events_i.link_up :
            (st_reg.link && events_i.link_up);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '{fsm: phy_status_pkg::S_IDLE, ones: 6'h00, cnt: 5'h00, hdr: 12'h000,
                        shift: 16'h0000, caps: phy_status_pkg::CAP_RST,
                        rsvd: phy_status_pkg::RSV_RST, pre_supp: phy_status_pkg::PRE_RST,
                        an_done: phy_status_pkg::LATCH_RST, rfault: phy_status_pkg::LATCH_RST,
                        link: phy_status_pkg::LATCH_RST, jab: phy_status_pkg::LATCH_RST,
                        ovr_en: phy_status_pkg::OVR_RST, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign mdio_o = st_reg.mdio_out;
    assign mdio_oe_o = st_reg.mdio_oe;
    assign caps_o = st_reg.caps;
    assign preamble_supp_o = st_reg.pre_supp;
    // Word as a read would see it now, for the checks below
    assign stat_word = status_word(st_reg);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_status_read;
        rd_pulse;
    endsequence
    sequence s_ta_then_msb;
        mdio_oe_o && !mdio_o ##[1:40] (mdio_oe_o && st_reg.fsm == phy_status_pkg::S_DATA);
    endsequence

    property p_fixed_bits;
        stat_word[15] == 1'b0 && stat_word[10:7] == 4'h0 &&
            stat_word[3] && stat_word[0];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("Fixed status bits wrong");
    property p_reset_defaults;
        $rose(arst_n_i) |-> caps_o == phy_status_pkg::CAP_RST && !preamble_supp_o &&
            !st_reg.an_done && !st_reg.link;
    endproperty
    a_reset_defaults: assert property (@(posedge clk_i) p_reset_defaults)
        else $error("Bad defaults");
    property p_cw_locked;
        wr_commit && !st_reg.ovr_en |=> $stable(caps_o) && $stable(preamble_supp_o);
    endproperty
    a_cw_locked: assert property (p_cw_locked) else $error("Locked write changed bits");
    property p_cw_write;
        wr_commit && st_reg.ovr_en && st_reg.hdr[4:0] == phy_status_pkg::STATUS_ADDR
            |=> caps_o == $past(wdata[14:11]) && preamble_supp_o == $past(wdata[6]);
    endproperty
    a_cw_write: assert property (p_cw_write) else $error("Override write lost");
    property p_an_latch;
        events_i.an_complete |=> st_reg.an_done;
    endproperty
    a_an_latch: assert property (p_an_latch)
        else $error("Negotiation flag not latched");
    property p_rfault_latch;
        events_i.remote_fault |=> st_reg.rfault;
    endproperty
    a_rfault_latch: assert property (p_rfault_latch)
        else $error("Remote fault not latched");
    property p_jab_hold;
        st_reg.jab && !rd_pulse |=> st_reg.jab;
    endproperty
    a_jab_hold: assert property (p_jab_hold)
        else $error("Jabber flag lost before read");
    property p_link_low;
        !events_i.link_up ##1 !rd_pulse[*2] |=> !st_reg.link;
    endproperty
    a_link_low: assert property (p_link_low) else $error("Link bit rose without read");
    property p_read_clear;
        s_status_read ##0 !events_i.jabber |=> !st_reg.jab;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Read did not clear jabber");
    property p_read_drive;
        s_status_read |=> s_ta_then_msb;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("Read answer not driven");
endmodule : phy_status_reg
`default_nettype wire

// file: rtl/sync_2ff.sv
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : sync_2ff
`default_nettype wire

// file: verification/mgmt_station_model.sv
`default_nettype none
module mgmt_station_model (
    input wire logic clk_i,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // One management clock period is 8 clk cycles; the station changes its data only while it is low
    task automatic bit_cycle(input logic drive, input logic d, output logic q);
        mdio_oe_o = drive;
        mdio_o = d;
        repeat (4) @(negedge clk_i);
        mdc_o = 1'b1;
        q = mdio_i;
        repeat (4) @(negedge clk_i);
        mdc_o = 1'b0;
    endtask : bit_cycle

    // Management clock stands still between frames, so the gap has no edges
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic q;
        logic wr;
        wr = (op == phy_status_pkg::OP_WRITE);
        hdr = {2'b01, op, pa, ra};
        if (pre) begin
            for (int i = 0; i < 32; i++) begin
                bit_cycle(1'b1, 1'b1, q);
            end
        end
        for (int i = 13; i >= 0; i--) begin
            bit_cycle(1'b1, hdr[i], q);
        end
        bit_cycle(wr, 1'b1, q);
        bit_cycle(wr, 1'b0, q);
        // Caller supplies reserved fields at their defaults on writes
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wd[i], q);
            rd[i] = q;
        end
        mdio_oe_o = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask : frame
endmodule : mgmt_station_model
`default_nettype wire

// file: verification/phy_status_reg_tb.sv
`default_nettype none
module phy_status_reg_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [4:0] PHYAD = 5'h05;
    localparam logic [4:0] REG1 = phy_status_pkg::STATUS_ADDR;
    localparam logic [4:0] REG16 = phy_status_pkg::EXT_CTRL_ADDR;
    localparam logic [1:0] RD = phy_status_pkg::OP_READ;
    localparam logic [1:0] WR = phy_status_pkg::OP_WRITE;

    typedef struct packed {
        logic [3:0] pulse;
        logic [3:0] hold;
        logic [15:0] word;
    } row_t;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic mdc;
    logic sm_mdio;
    logic sm_oe;
    logic dut_mdio;
    logic dut_oe;
    logic mdio_line;
    phy_status_pkg::phy_events_t events = '0;
    logic [3:0] caps;
    logic pre_supp;
    logic [15:0] rd;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Event pulse, level held through the read, expected status word
    row_t rows [11] = '{24'h027809, 24'h22780D, 24'hA2782D, 24'h22780D, 24'h62781D,
        24'h32780F, 24'h027809, 24'h22780D, 24'hFF783F, 24'hF2783F, 24'h22780D};

    always #50 clk = ~clk;

    // Pull-up on the shared data line; nobody driving reads as one
    assign mdio_line = dut_oe ? dut_mdio : (sm_oe ? sm_mdio : 1'b1);

    phy_status_reg #(.PHY_ADDR(PHYAD)) u_dut (
        .clk_i(clk),
        .arst_n_i(arst_n),
        .mdc_i(mdc),
        .mdio_i(mdio_line),
        .mdio_o(dut_mdio),
        .mdio_oe_o(dut_oe),
        .events_i(events),
        .caps_o(caps),
        .preamble_supp_o(pre_supp)
    );

    mgmt_station_model u_sm (
        .clk_i(clk),
        .mdio_i(mdio_line),
        .mdc_o(mdc),
        .mdio_o(sm_mdio),
        .mdio_oe_o(sm_oe)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // About 20 frames of at most 520 cycles each; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        check({10'h000, dut_oe, caps, pre_supp}, 16'h001E);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 11; i++) begin
            events = rows[i].pulse;
            repeat (2) @(negedge clk);
            events = rows[i].hold;
            u_sm.frame(1'b1, RD, PHYAD, REG1, 16'h0000, rd);
            check(rd, rows[i].word);
        end
        // Override off: capability and preamble bits keep their defaults
        u_sm.frame(1'b1, WR, PHYAD, REG1, 16'h0049, rd);
        check({11'h000, caps, pre_supp}, 16'h001E);
        u_sm.frame(1'b1, WR, PHYAD, REG16, 16'h8000, rd);
        u_sm.frame(1'b1, WR, PHYAD, REG1, 16'h5049, rd);
        check({11'h000, caps, pre_supp}, 16'h0015);
        // Preamble now optional; bit 15 and reserved bits still read zero
        u_sm.frame(1'b0, RD, PHYAD, REG1, 16'h0000, rd);
        check(rd, 16'h504D);
        u_sm.frame(1'b1, RD, PHYAD, 5'h05, 16'h0000, rd);
        check(rd, 16'h0000);
        u_sm.frame(1'b1, RD, 5'h03, REG1, 16'h0000, rd);
        check(rd, 16'hFFFF);
        u_sm.frame(1'b1, WR, PHYAD, REG16, 16'h0000, rd);
        u_sm.frame(1'b1, WR, PHYAD, REG1, 16'h7809, rd);
        check({11'h000, caps, pre_supp}, 16'h0015);
        // Second reset in mid-run restores every default
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({10'h000, dut_oe, caps, pre_supp}, 16'h001E);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        u_sm.frame(1'b1, RD, PHYAD, REG1, 16'h0000, rd);
        check(rd, 16'h7809);
        print_verdict();
    end
endmodule : phy_status_reg_tb
`default_nettype wire
